// ===== common/dpsc_pkg.sv
// Package for the per-channel shared-memory channel block.
// Assumes byte offsets relative to the dual-port memory base.
package dpsc_pkg;
   // Channel control area word offsets
   localparam logic [15:0] OFF_DATA_FMT = 16'h0002;
   localparam logic [15:0] OFF_LINE_PROTO = 16'h0004;
   localparam logic [15:0] OFF_CHAN_CMD = 16'h0014;
   localparam logic [15:0] OFF_CHAN_RESULT = 16'h0016;
   localparam logic [15:0] OFF_IBUF_START = 16'h0018;
   localparam logic [15:0] OFF_IBUF_END = 16'h001A;
   localparam logic [15:0] OFF_OBUF_START = 16'h001C;
   localparam logic [15:0] OFF_OBUF_END = 16'h001E;
   localparam logic [15:0] OFF_IN_PROD = 16'h0020;
   localparam logic [15:0] OFF_IN_CONS = 16'h0022;
   localparam logic [15:0] OFF_OUT_PROD = 16'h0024;
   localparam logic [15:0] OFF_OUT_CONS = 16'h0026;
   localparam logic [15:0] OFF_ERR_STAT = 16'h0028;
   localparam logic [15:0] OFF_BAD_PTR = 16'h002A;
   localparam logic [15:0] OFF_BLOCK_STAT = 16'h0030;
   localparam logic [15:0] OFF_RX_FLAG = 16'h0032;
   localparam logic [15:0] OFF_FLOW_CHARS = 16'h0034;
   localparam logic [15:0] OFF_ACT_STAT = 16'h0036;
   // Service request and interrupt words of the global control area
   localparam logic [15:0] OFF_SRQ_ERR = 16'h0038;
   localparam logic [15:0] OFF_SRQ_GLOBAL = 16'h003A;
   localparam logic [15:0] OFF_GCMD2 = 16'h003C;
   // Buffer area and default buffer bounds
   localparam logic [15:0] BUF_BASE = 16'h0040;
   localparam logic [15:0] IBUF_START_DEF = 16'h0040;
   localparam logic [15:0] IBUF_END_DEF = 16'h013F;
   localparam logic [15:0] OBUF_START_DEF = 16'h0140;
   localparam logic [15:0] OBUF_END_DEF = 16'h023F;
   // Field values
   localparam logic [15:0] RX_FLAG_SET = 16'hFFFF;
   localparam logic [7:0] ERR_SUB_CHAR = 8'hFF;
   localparam logic [7:0] FLOW_START_DEF = 8'h11;
   localparam logic [7:0] FLOW_STOP_DEF = 8'h13;
   localparam logic [15:0] RES_OK = 16'h0000;
   localparam logic [15:0] RES_BAD_FLOW = 16'h0008;
   localparam logic [15:0] RES_UART_DEAD = 16'h000B;
   // Bit positions
   localparam int FMT_KEEP_BAD_BIT = 8;
   localparam int LP_MODEM_BIT = 0;
   localparam int LP_RTS_BIT = 1;
   localparam int LP_FLOW_BIT = 2;
   localparam int CMD_CFG_BIT = 0;
   localparam int CMD_CFG_NU_BIT = 1;
   localparam int CMD_FLUSH_IN_BIT = 2;
   localparam int CMD_FLUSH_OUT_BIT = 3;
   localparam int CMD_RX_ON_BIT = 4;
   localparam int CMD_RX_OFF_BIT = 5;
   localparam int CMD_TX_ON_BIT = 6;
   localparam int CMD_TX_OFF_BIT = 7;
   localparam int GCMD2_ACK_BIT = 0;
   localparam int SRQ_CHAN_BIT = 0;
   localparam int SRQ_GLOB_ERR_BIT = 0;
   // Receive sequence states
   typedef enum logic [2:0] {
      RX_IDLE = 3'b000,
      RX_STORE = 3'b001,
      RX_SRQ_ERR = 3'b010,
      RX_SRQ_GLOB = 3'b011,
      RX_ADVANCE = 3'b100,
      RX_IRQ = 3'b101
   } dpsc_rx_e;
endpackage

// ===== hw/dpsc_mem.sv
// Byte buffer memory shared by host and channel logic.
// Assumes one clock; read data appear one cycle after the request.
`timescale 1ns/10ps
module dpsc_mem #(
   parameter int DEPTH = 512,
   parameter int AW = 9
) (
   // Clock
   input wire logic mclk_in,
   // Host side port
   input wire logic a_en_in,
   input wire logic a_we_in,
   input wire logic [AW-1:0] a_addr_in,
   input wire logic [7:0] a_wdata_in,
   output logic [7:0] a_rdata_out,
   // Channel side port
   input wire logic b_en_in,
   input wire logic b_we_in,
   input wire logic [AW-1:0] b_addr_in,
   input wire logic [7:0] b_wdata_in,
   output logic [7:0] b_rdata_out
);
   // Storage array
   logic [7:0] mem_q [DEPTH];

   // Both ports in one process; channel write lands last on a clash
   always_ff @(posedge mclk_in) begin
      if (a_en_in && a_we_in) begin
         mem_q[a_addr_in] <= a_wdata_in;
      end
      if (b_en_in && b_we_in) begin
         mem_q[b_addr_in] <= b_wdata_in;
      end
      // Registered reads, old data on a same-cycle write
      if (a_en_in) begin
         a_rdata_out <= mem_q[a_addr_in];
      end
      if (b_en_in) begin
         b_rdata_out <= mem_q[b_addr_in];
      end
   end
endmodule

// ===== hw/dpsc_channel.sv
// One serial channel's shared-memory interface: control words, ring buffers.
// Assumes the host port and line engine signals are synchronous to mclk_in.
`timescale 1ns/10ps
// How it works
// - Blocking bits 3, 5 gated by protocol
// - Every received character sets flag FFFF
// - Flow characters, defaults 11H/13H when zero
// - Status bit0 while output pending or busy
// - Device drains output with own consumer
// - Unequal input pointers mean characters waiting
// - Never overwrite characters host has unread
// - Bad character stored as FFH or raw
// - Bad pointer loaded only when zero
// - Error bit, requests, advance, then interrupt
// - Error status accumulates across characters
// - Command cleared to zero, result code left
// - Defaults loaded when control starts
// - Finish handling before requests and interrupt
// - Acknowledge bit enables, pending fires at once
// - Store at producer, advance, wrap
// - Result codes 0000H through 000BH
// - Error indications kept until host clears
module dpsc_channel #(
   parameter int DEPTH = 512,
   parameter int AW = 9,
   parameter logic [15:0] IN_START = dpsc_pkg::IBUF_START_DEF,
   parameter logic [15:0] IN_END = dpsc_pkg::IBUF_END_DEF,
   parameter logic [15:0] OUT_START = dpsc_pkg::OBUF_START_DEF,
   parameter logic [15:0] OUT_END = dpsc_pkg::OBUF_END_DEF
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic reset_in,
   // Host dual-port access
   input wire logic [15:0] hp_addr_in,
   input wire logic hp_rd_in,
   input wire logic hp_wr_in,
   input wire logic hp_xchg_in,
   input wire logic [15:0] hp_wdata_in,
   output logic [15:0] hp_rdata_out,
   output logic hp_rvalid_out,
   output logic host_irq_out,
   // Receive side of the line engine
   input wire logic rx_valid_in,
   input wire logic [7:0] rx_char_in,
   input wire logic [3:0] rx_err_in,
   output logic rx_ready_out,
   output logic rx_enable_out,
   // Transmit side of the line engine
   output logic tx_valid_out,
   output logic [7:0] tx_data_out,
   input wire logic tx_ready_in,
   input wire logic tx_busy_in,
   output logic tx_enable_out,
   // Flow control and line state
   output logic rx_flow_pause_send_out,
   output logic [7:0] flow_start_char_out,
   output logic [7:0] flow_stop_char_out,
   input wire logic cts_blocked_in,
   input wire logic rts_negated_in,
   input wire logic [1:0] xoff_state_in,
   input wire logic uart_fault_in
);
   // Whole block state
   typedef struct packed {
      logic [15:0] data_fmt;
      logic [15:0] line_proto;
      logic [15:0] chan_cmd;
      logic [15:0] chan_result;
      logic [15:0] in_prod;
      logic [15:0] in_cons;
      logic [15:0] out_prod;
      logic [15:0] out_cons;
      logic [15:0] err_stat;
      logic [15:0] bad_ptr;
      logic [15:0] block_stat;
      logic [15:0] rx_flag;
      logic [15:0] flow_chars;
      logic [15:0] act_stat;
      logic [15:0] srq_err;
      logic [15:0] srq_glob;
      logic [15:0] gcmd2;
      dpsc_pkg::dpsc_rx_e rx_st;
      logic [7:0] rx_char;
      logic [3:0] rx_err;
      logic rx_en;
      logic tx_en;
      logic rx_ready;
      logic fetch;
      logic [1:0] tb_v;
      logic [7:0] tb0;
      logic [7:0] tb1;
      logic [7:0] flow_start;
      logic [7:0] flow_stop;
      logic rd_pend;
      logic rd_mem;
      logic [15:0] rd_reg;
      logic rv;
      logic [15:0] rdata;
      logic irq;
   } dpsc_state_s;

   dpsc_state_s s_q; // Registered state
   dpsc_state_s s_d; // Next state

   // Memory port wiring
   logic a_en; // Host port enable
   logic a_we; // Host port write
   logic [AW-1:0] a_addr; // Host port byte index
   logic [7:0] a_rdata; // Host port read data
   logic b_en; // Channel port enable
   logic b_we; // Channel port write
   logic [AW-1:0] b_addr; // Channel port byte index
   logic [7:0] b_wdata; // Channel port write data
   logic [7:0] b_rdata; // Channel port read data
   logic [15:0] reg_rdata; // Word read mux
   logic [15:0] h_off; // Offset into buffer area
   logic h_in_buf; // Host address hits buffer area

   function automatic logic [15:0] dpsc_next(input logic [15:0] p, input logic [15:0] first,
                                             input logic [15:0] last);
      logic [16:0] n;
      n = {1'b0, p} + 17'h0_0001;
      dpsc_next = (n > {1'b0, last}) ? first : n[15:0];
   endfunction

   function automatic logic [AW-1:0] dpsc_idx(input logic [15:0] p);
      logic [15:0] d;
      d = p - dpsc_pkg::BUF_BASE;
      dpsc_idx = d[AW-1:0];
   endfunction

   // Buffer area decode for host accesses
   always_comb begin
      h_off = hp_addr_in - dpsc_pkg::BUF_BASE;
      h_in_buf = (hp_addr_in >= dpsc_pkg::BUF_BASE) && (h_off < DEPTH[15:0]);
   end

   // Word read mux over the control area; unmapped words read zero
   always_comb begin
      unique case (hp_addr_in)
         dpsc_pkg::OFF_DATA_FMT: reg_rdata = s_q.data_fmt;
         dpsc_pkg::OFF_LINE_PROTO: reg_rdata = s_q.line_proto;
         dpsc_pkg::OFF_CHAN_CMD: reg_rdata = s_q.chan_cmd;
         dpsc_pkg::OFF_CHAN_RESULT: reg_rdata = s_q.chan_result;
         dpsc_pkg::OFF_IBUF_START: reg_rdata = IN_START;
         dpsc_pkg::OFF_IBUF_END: reg_rdata = IN_END;
         dpsc_pkg::OFF_OBUF_START: reg_rdata = OUT_START;
         dpsc_pkg::OFF_OBUF_END: reg_rdata = OUT_END;
         dpsc_pkg::OFF_IN_PROD: reg_rdata = s_q.in_prod;
         dpsc_pkg::OFF_IN_CONS: reg_rdata = s_q.in_cons;
         dpsc_pkg::OFF_OUT_PROD: reg_rdata = s_q.out_prod;
         dpsc_pkg::OFF_OUT_CONS: reg_rdata = s_q.out_cons;
         dpsc_pkg::OFF_ERR_STAT: reg_rdata = s_q.err_stat;
         dpsc_pkg::OFF_BAD_PTR: reg_rdata = s_q.bad_ptr;
         dpsc_pkg::OFF_BLOCK_STAT: reg_rdata = s_q.block_stat;
         dpsc_pkg::OFF_RX_FLAG: reg_rdata = s_q.rx_flag;
         dpsc_pkg::OFF_FLOW_CHARS: reg_rdata = s_q.flow_chars;
         dpsc_pkg::OFF_ACT_STAT: reg_rdata = s_q.act_stat;
         dpsc_pkg::OFF_SRQ_ERR: reg_rdata = s_q.srq_err;
         dpsc_pkg::OFF_SRQ_GLOBAL: reg_rdata = s_q.srq_glob;
         dpsc_pkg::OFF_GCMD2: reg_rdata = s_q.gcmd2;
         default: reg_rdata = 16'h0000;
      endcase
   end

   // Next-state logic; host writes first so hardware sets win after them
   always_comb begin
      s_d = s_q;
      s_d.irq = 1'b0;
      a_en = 1'b0;
      a_we = 1'b0;
      a_addr = h_off[AW-1:0];
      b_en = 1'b0;
      b_we = 1'b0;
      b_addr = dpsc_idx(s_q.in_prod);
      b_wdata = s_q.rx_char;

      // Host read: snapshot word now, memory data a cycle later
      s_d.rd_pend = hp_rd_in || hp_xchg_in;
      s_d.rd_mem = (hp_rd_in || hp_xchg_in) && h_in_buf;
      s_d.rd_reg = reg_rdata;
      s_d.rv = s_q.rd_pend;
      s_d.rdata = s_q.rd_mem ? {8'h00, a_rdata} : s_q.rd_reg;
      if ((hp_rd_in || hp_xchg_in || hp_wr_in) && h_in_buf) begin
         a_en = 1'b1;
         a_we = hp_wr_in || hp_xchg_in;
      end

      // Host writes; an exchange writes in the cycle it reads
      if (hp_wr_in || hp_xchg_in) begin
         unique case (hp_addr_in)
            dpsc_pkg::OFF_DATA_FMT: s_d.data_fmt = hp_wdata_in;
            dpsc_pkg::OFF_LINE_PROTO: s_d.line_proto = hp_wdata_in;
            dpsc_pkg::OFF_CHAN_CMD: s_d.chan_cmd = hp_wdata_in;
            dpsc_pkg::OFF_IN_CONS: s_d.in_cons = hp_wdata_in;
            dpsc_pkg::OFF_OUT_PROD: s_d.out_prod = hp_wdata_in;
            dpsc_pkg::OFF_ERR_STAT: s_d.err_stat = hp_wdata_in;
            dpsc_pkg::OFF_BAD_PTR: s_d.bad_ptr = hp_wdata_in;
            dpsc_pkg::OFF_RX_FLAG: s_d.rx_flag = hp_wdata_in;
            dpsc_pkg::OFF_FLOW_CHARS: s_d.flow_chars = hp_wdata_in;
            dpsc_pkg::OFF_SRQ_ERR: s_d.srq_err = hp_wdata_in;
            dpsc_pkg::OFF_SRQ_GLOBAL: s_d.srq_glob = hp_wdata_in;
            dpsc_pkg::OFF_GCMD2: s_d.gcmd2 = hp_wdata_in;
            // Read-only and unmapped words ignore writes
            default: s_d.gcmd2 = s_d.gcmd2;
         endcase
      end

      // Receive sequence, one step per cycle so ordering is visible
      unique case (s_q.rx_st)
         dpsc_pkg::RX_IDLE: begin
            if (rx_valid_in && s_q.rx_ready) begin
               s_d.rx_char = rx_char_in;
               s_d.rx_err = rx_err_in;
               s_d.rx_st = dpsc_pkg::RX_STORE;
            end
         end
         dpsc_pkg::RX_STORE: begin
            b_en = 1'b1;
            b_we = 1'b1;
            if (s_q.rx_err != 4'h0 && !s_q.data_fmt[dpsc_pkg::FMT_KEEP_BAD_BIT]) begin
               b_wdata = dpsc_pkg::ERR_SUB_CHAR;
            end
            s_d.rx_flag = dpsc_pkg::RX_FLAG_SET;
            if (s_q.rx_err != 4'h0) begin
               if (s_d.bad_ptr == 16'h0000) begin
                  s_d.bad_ptr = s_q.in_prod;
               end
               s_d.err_stat = s_d.err_stat | {12'h000, s_q.rx_err};
               s_d.rx_st = dpsc_pkg::RX_SRQ_ERR;
            end else begin
               s_d.rx_st = dpsc_pkg::RX_ADVANCE;
            end
         end
         dpsc_pkg::RX_SRQ_ERR: begin
            s_d.srq_err[dpsc_pkg::SRQ_CHAN_BIT] = 1'b1;
            s_d.rx_st = dpsc_pkg::RX_SRQ_GLOB;
         end
         dpsc_pkg::RX_SRQ_GLOB: begin
            s_d.srq_glob[dpsc_pkg::SRQ_GLOB_ERR_BIT] = 1'b1;
            s_d.rx_st = dpsc_pkg::RX_ADVANCE;
         end
         dpsc_pkg::RX_ADVANCE: begin
            s_d.in_prod = dpsc_next(s_q.in_prod, IN_START, IN_END);
            s_d.rx_st = (s_q.rx_err != 4'h0) ? dpsc_pkg::RX_IRQ : dpsc_pkg::RX_IDLE;
         end
         dpsc_pkg::RX_IRQ: begin
            // Interrupt decision below sees this step
            s_d.rx_st = dpsc_pkg::RX_IDLE;
         end
         default: s_d.rx_st = dpsc_pkg::RX_IDLE;
      endcase

      // Transmit buffer: pop head when line engine takes it
      if (s_q.tb_v[0] && tx_ready_in) begin
         s_d.tb0 = s_q.tb1;
         s_d.tb_v = {1'b0, s_q.tb_v[1]};
      end
      // Fetched byte lands in the first free entry
      if (s_q.fetch) begin
         if (!s_d.tb_v[0]) begin
            s_d.tb0 = b_rdata;
            s_d.tb_v[0] = 1'b1;
         end else begin
            s_d.tb1 = b_rdata;
            s_d.tb_v[1] = 1'b1;
         end
      end
      s_d.fetch = 1'b0;
      if (s_q.rx_st != dpsc_pkg::RX_STORE && s_q.tx_en && s_q.out_prod != s_q.out_cons
          && !s_d.tb_v[1]) begin
         // Stall here while both entries are held, so no byte is lost
         b_en = 1'b1;
         b_addr = dpsc_idx(s_q.out_cons);
         s_d.out_cons = dpsc_next(s_q.out_cons, OUT_START, OUT_END);
         s_d.fetch = 1'b1;
      end

      // Channel command, taken only between receive sequences
      if (s_q.chan_cmd != 16'h0000 && s_q.rx_st == dpsc_pkg::RX_IDLE
          && !((hp_wr_in || hp_xchg_in) && hp_addr_in == dpsc_pkg::OFF_CHAN_CMD)) begin
         if (s_q.chan_cmd[dpsc_pkg::CMD_FLUSH_IN_BIT]) begin
            s_d.in_prod = IN_START;
            s_d.in_cons = IN_START;
         end
         if (s_q.chan_cmd[dpsc_pkg::CMD_FLUSH_OUT_BIT]) begin
            // Drop held and in-flight bytes with the pointers
            s_d.out_prod = OUT_START;
            s_d.out_cons = OUT_START;
            s_d.tb_v = 2'b00;
            s_d.fetch = 1'b0;
         end
         if (s_q.chan_cmd[dpsc_pkg::CMD_RX_ON_BIT]) begin
            s_d.rx_en = 1'b1;
         end
         if (s_q.chan_cmd[dpsc_pkg::CMD_RX_OFF_BIT]) begin
            s_d.rx_en = 1'b0;
         end
         if (s_q.chan_cmd[dpsc_pkg::CMD_TX_ON_BIT]) begin
            s_d.tx_en = 1'b1;
         end
         if (s_q.chan_cmd[dpsc_pkg::CMD_TX_OFF_BIT]) begin
            s_d.tx_en = 1'b0;
         end
         if (uart_fault_in) begin
            s_d.chan_result = dpsc_pkg::RES_UART_DEAD;
         end else if ((s_q.chan_cmd[dpsc_pkg::CMD_CFG_BIT]
                       || s_q.chan_cmd[dpsc_pkg::CMD_CFG_NU_BIT])
                      && ((s_q.flow_chars[15:8] == 8'h00) != (s_q.flow_chars[7:0] == 8'h00))) begin
            s_d.chan_result = dpsc_pkg::RES_BAD_FLOW;
         end else begin
            s_d.chan_result = dpsc_pkg::RES_OK;
         end
         s_d.chan_cmd = 16'h0000;
      end

      if (s_d.gcmd2[dpsc_pkg::GCMD2_ACK_BIT] && s_d.srq_glob != 16'h0000
          && (s_q.rx_st == dpsc_pkg::RX_IDLE || s_q.rx_st == dpsc_pkg::RX_IRQ)) begin
         // Acknowledge bit is spent; handler re-arms it
         s_d.irq = 1'b1;
         s_d.gcmd2[dpsc_pkg::GCMD2_ACK_BIT] = 1'b0;
      end

      s_d.act_stat[0] = (s_d.out_prod != s_d.out_cons) || (s_d.tb_v != 2'b00) || s_d.fetch
                        || tx_busy_in;

      // Blocking status from enables and line engine
      s_d.block_stat[0] = !s_d.rx_en;
      s_d.block_stat[1] = !s_d.tx_en;
      s_d.block_stat[2] = xoff_state_in[0];
      s_d.block_stat[4] = xoff_state_in[1];
      if (s_q.line_proto[dpsc_pkg::LP_MODEM_BIT]) begin
         s_d.block_stat[3] = cts_blocked_in;
      end
      if (s_q.line_proto[dpsc_pkg::LP_RTS_BIT]) begin
         s_d.block_stat[5] = rts_negated_in;
      end

      if (s_d.flow_chars == 16'h0000) begin
         s_d.flow_start = dpsc_pkg::FLOW_START_DEF;
         s_d.flow_stop = dpsc_pkg::FLOW_STOP_DEF;
      end else begin
         s_d.flow_start = s_d.flow_chars[7:0];
         s_d.flow_stop = s_d.flow_chars[15:8];
      end

      s_d.rx_ready = (s_d.rx_st == dpsc_pkg::RX_IDLE) && s_d.rx_en
                     && (dpsc_next(s_d.in_prod, IN_START, IN_END) != s_d.in_cons);
   end

   // State register
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         s_q <= '0;
         s_q.in_prod <= IN_START;
         s_q.in_cons <= IN_START;
         s_q.out_prod <= OUT_START;
         s_q.out_cons <= OUT_START;
         s_q.rx_en <= 1'b1;
         s_q.tx_en <= 1'b1;
         s_q.flow_start <= dpsc_pkg::FLOW_START_DEF;
         s_q.flow_stop <= dpsc_pkg::FLOW_STOP_DEF;
      end else begin
         s_q <= s_d;
      end
   end

   // Shared byte buffers
   dpsc_mem #(
      .DEPTH(DEPTH),
      .AW(AW)
   ) u_mem (
      .mclk_in(mclk_in),
      .a_en_in(a_en),
      .a_we_in(a_we),
      .a_addr_in(a_addr),
      .a_wdata_in(hp_wdata_in[7:0]),
      .a_rdata_out(a_rdata),
      .b_en_in(b_en),
      .b_we_in(b_we),
      .b_addr_in(b_addr),
      .b_wdata_in(b_wdata),
      .b_rdata_out(b_rdata)
   );

   // Outputs straight from state
   assign hp_rdata_out = s_q.rdata;
   assign hp_rvalid_out = s_q.rv;
   assign host_irq_out = s_q.irq;
   assign rx_ready_out = s_q.rx_ready;
   assign rx_enable_out = s_q.rx_en;
   assign tx_valid_out = s_q.tb_v[0];
   assign tx_data_out = s_q.tb0;
   assign tx_enable_out = s_q.tx_en;
   assign rx_flow_pause_send_out = s_q.line_proto[dpsc_pkg::LP_FLOW_BIT];
   assign flow_start_char_out = s_q.flow_start;
   assign flow_stop_char_out = s_q.flow_stop;
endmodule

// ===== bench/dpsc_channel_properties.sv
// Port checks for one channel block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module dpsc_channel_properties (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic reset_in,
   // Host port
   input wire logic hp_rd_in,
   input wire logic hp_xchg_in,
   input wire logic hp_rvalid_out,
   input wire logic host_irq_out,
   // Line side
   input wire logic rx_valid_in,
   input wire logic [3:0] rx_err_in,
   input wire logic rx_ready_out,
   input wire logic rx_enable_out,
   input wire logic tx_valid_out,
   input wire logic [7:0] tx_data_out,
   input wire logic tx_ready_in,
   input wire logic [7:0] flow_start_char_out,
   input wire logic [7:0] flow_stop_char_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (reset_in);
   // Request and take helpers
   wire logic rq = hp_rd_in || hp_xchg_in;
   wire logic take = rx_valid_in && rx_ready_out;
   AST_RD_LAT: assert property (rq |-> ##2 hp_rvalid_out)
      else $error("read answer not two cycles later");
   AST_RD_CAUSE: assert property (hp_rvalid_out |-> $past(rq, 2))
      else $error("answer without a read");
   AST_RX_BUSY: assert property (take |=> !rx_ready_out ##1 !rx_ready_out)
      else $error("ready back too soon");
   AST_ERR_ORDER: assert property (take && rx_err_in != 4'h0 |=> ##2 !host_irq_out[*2])
      else $error("interrupt before pointer advance");
   AST_RX_OFF: assert property (!rx_enable_out |-> !rx_ready_out)
      else $error("ready while receiver off");
   AST_IRQ_ONCE: assert property (host_irq_out |=> !host_irq_out)
      else $error("interrupt longer than a pulse");
   AST_TX_HOLD: assert property (tx_valid_out && !tx_ready_in |=>
      tx_valid_out && $stable(tx_data_out))
      else $error("transmit byte dropped or changed");
   AST_FLOW_DEF: assert property (flow_start_char_out != 8'h00 || flow_stop_char_out != 8'h00)
      else $error("both flow characters zero");
   // Main scenarios reached
   COV_ERR: cover property (take && rx_err_in != 4'h0);
   COV_IRQ: cover property (host_irq_out);
   COV_TX: cover property (tx_valid_out && tx_ready_in);
endmodule
bind dpsc_channel dpsc_channel_properties props_i (.mclk_in(mclk_in), .reset_in(reset_in),
   .hp_rd_in(hp_rd_in), .hp_xchg_in(hp_xchg_in), .hp_rvalid_out(hp_rvalid_out),
   .host_irq_out(host_irq_out), .rx_valid_in(rx_valid_in), .rx_err_in(rx_err_in),
   .rx_ready_out(rx_ready_out), .rx_enable_out(rx_enable_out), .tx_valid_out(tx_valid_out),
   .tx_data_out(tx_data_out), .tx_ready_in(tx_ready_in),
   .flow_start_char_out(flow_start_char_out), .flow_stop_char_out(flow_stop_char_out));

// ===== bench/dpsc_host_model.sv
// Host program model driving the shared-memory port.
// Assumes answers come on hp_rvalid_in a few cycles after a read.
`timescale 1ns/10ps
module dpsc_host_model (
   // Clock
   input wire logic mclk_in,
   // Requests
   output logic [15:0] hp_addr_out,
   output logic hp_rd_out,
   output logic hp_wr_out,
   output logic hp_xchg_out,
   output logic [15:0] hp_wdata_out,
   // Answers
   input wire logic [15:0] hp_rdata_in,
   input wire logic hp_rvalid_in
);
   // Idle port from time zero
   initial begin
      hp_addr_out = 16'h0000;
      hp_wdata_out = 16'h0000;
      hp_rd_out = 1'b0;
      hp_wr_out = 1'b0;
      hp_xchg_out = 1'b0;
   end
   // One access: 0 write, 1 read, 2 exchange; one-cycle strobe
   task automatic acc(input int k, input logic [15:0] a, input logic [15:0] d,
      output logic [15:0] q);
      int n;
      @(posedge mclk_in);
      hp_addr_out <= a;
      hp_wdata_out <= d;
      hp_wr_out <= (k == 0);
      hp_rd_out <= (k == 1);
      // old value back, d written, one access
      hp_xchg_out <= (k == 2);
      @(posedge mclk_in);
      hp_wr_out <= 1'b0;
      hp_rd_out <= 1'b0;
      hp_xchg_out <= 1'b0;
      n = 0;
      // Bounded wait, so a lost answer cannot hang
      while (k != 0 && !hp_rvalid_in && n < 8) begin
         @(posedge mclk_in);
         n++;
      end
      // No answer reads unknown
      q = (k == 0 || hp_rvalid_in) ? hp_rdata_in : 16'hxxxx;
   endtask
endmodule

// ===== bench/testbench.sv
// Self-checking bench: host accesses, receive, errors, commands, transmit.
// Assumes the host model owns the host port and the bench the line side.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
   // Clock, reset, counters
   logic mclk_in, reset_in, tx_en;
   int miscompares, num_checks, n;
   // Host port and line side nets
   logic [15:0] ha, hw, hr, q;
   logic hrd, hwr, hxc, hv, irq, rx_valid, rx_ready, rx_en, tx_valid, tx_ready, tx_busy, pause;
   logic [7:0] rx_char, tx_data, fs, fp;
   logic [3:0] rx_err;
   dpsc_host_model host_i (.mclk_in(mclk_in), .hp_addr_out(ha), .hp_rd_out(hrd),
      .hp_wr_out(hwr), .hp_xchg_out(hxc), .hp_wdata_out(hw), .hp_rdata_in(hr), .hp_rvalid_in(hv));
   // Blocking inputs held asserted; fault and xoff state held idle
   dpsc_channel dpsc_channel_i (.mclk_in(mclk_in), .reset_in(reset_in), .hp_addr_in(ha),
      .hp_rd_in(hrd), .hp_wr_in(hwr), .hp_xchg_in(hxc), .hp_wdata_in(hw), .hp_rdata_out(hr),
      .hp_rvalid_out(hv), .host_irq_out(irq), .rx_valid_in(rx_valid), .rx_char_in(rx_char),
      .rx_err_in(rx_err), .rx_ready_out(rx_ready), .rx_enable_out(rx_en),
      .tx_valid_out(tx_valid), .tx_data_out(tx_data), .tx_ready_in(tx_ready),
      .tx_busy_in(tx_busy), .tx_enable_out(tx_en), .rx_flow_pause_send_out(pause),
      .flow_start_char_out(fs), .flow_stop_char_out(fp), .cts_blocked_in(1'b1),
      .rts_negated_in(1'b1), .xoff_state_in(2'b00), .uart_fault_in(1'b0));
   // 100 ns clock
   initial begin
      mclk_in = 1'b0;
      forever #50 mclk_in = ~mclk_in;
   end
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      host_i.acc(0, a, d, q);
   endtask
   task automatic rd(input logic [15:0] a);
      host_i.acc(1, a, 16'h0000, q);
   endtask
   // Offer a character, hold it until taken, then let the sequence finish
   task automatic rx_send(input logic [7:0] c, input logic [3:0] e);
      int k;
      @(posedge mclk_in);
      rx_char <= c;
      rx_err <= e;
      rx_valid <= 1'b1;
      k = 0;
      do begin
         @(posedge mclk_in);
         k++;
      end while (!rx_ready && k < 50);
      rx_valid <= 1'b0;
      repeat (8) @(posedge mclk_in);
   endtask
   task automatic end_sim;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Cut a hang short
   initial begin
      repeat (20000) @(posedge mclk_in);
      miscompares++;
      end_sim();
   end
   initial begin
      reset_in = 1'b1;
      rx_valid = 1'b0;
      rx_char = 8'h00;
      rx_err = 4'h0;
      tx_ready = 1'b0;
      tx_busy = 1'b0;
      repeat (12) @(posedge mclk_in);
      reset_in <= 1'b0;
      rd(dpsc_pkg::OFF_IN_PROD);
      `CHK("in_prod", 16'h0040, q)
      `CHK("start", 8'h11, fs)
      `CHK("stop", 8'h13, fp)
      `CHK("tx_en", 1'b1, tx_en)
      rd(dpsc_pkg::OFF_BLOCK_STAT);
      `CHK("block", 16'h0000, q & 16'h0028)
      rx_send(8'h41, 4'h0);
      rd(dpsc_pkg::OFF_RX_FLAG);
      `CHK("rx_flag", 16'hFFFF, q)
      rd(dpsc_pkg::OFF_IN_PROD);
      `CHK("in_prod", 16'h0041, q)
      rd(16'h0040);
      `CHK("char", 16'h0041, q)
      wr(dpsc_pkg::OFF_RX_FLAG, 16'h0000);
      rx_send(8'h5A, 4'h2);
      rx_send(8'h5B, 4'h4);
      rd(16'h0041);
      `CHK("sub", 16'h00FF, q)
      rd(dpsc_pkg::OFF_BAD_PTR);
      `CHK("bad_ptr", 16'h0041, q)
      host_i.acc(2, dpsc_pkg::OFF_ERR_STAT, 16'h0000, q);
      `CHK("err", 16'h0006, q)
      wr(dpsc_pkg::OFF_BAD_PTR, 16'h0000);
      rd(dpsc_pkg::OFF_IN_PROD);
      `CHK("in_prod", 16'h0043, q)
      wr(dpsc_pkg::OFF_IN_CONS, 16'h0043);
      // Requests pending before enabling: interrupt must follow within ten cycles
      wr(dpsc_pkg::OFF_GCMD2, 16'h0001);
      n = 0;
      while (irq !== 1'b1 && n < 10) begin
         @(posedge mclk_in);
         n++;
      end
      `CHK("irq", 1'b1, irq)
      host_i.acc(2, dpsc_pkg::OFF_SRQ_GLOBAL, 16'h0000, q);
      `CHK("srq_glob", 16'h0001, q)
      host_i.acc(2, dpsc_pkg::OFF_SRQ_GLOBAL, 16'h0000, q);
      `CHK("srq_clr", 16'h0000, q)
      wr(dpsc_pkg::OFF_FLOW_CHARS, 16'h2A3C);
      wr(dpsc_pkg::OFF_LINE_PROTO, 16'h0005);
      wr(dpsc_pkg::OFF_DATA_FMT, 16'h0100);
      wr(dpsc_pkg::OFF_CHAN_CMD, 16'h0001);
      rd(dpsc_pkg::OFF_CHAN_CMD);
      `CHK("cmd", 16'h0000, q)
      rd(dpsc_pkg::OFF_CHAN_RESULT);
      `CHK("result", 16'h0000, q)
      `CHK("pause", 1'b1, pause)
      `CHK("start", 8'h3C, fs)
      `CHK("stop", 8'h2A, fp)
      rd(dpsc_pkg::OFF_BLOCK_STAT);
      `CHK("block", 16'h0008, q & 16'h0028)
      rx_send(8'h77, 4'h1);
      rd(16'h0043);
      `CHK("raw", 16'h0077, q)
      wr(dpsc_pkg::OFF_FLOW_CHARS, 16'h1300);
      wr(dpsc_pkg::OFF_CHAN_CMD, 16'h0001);
      rd(dpsc_pkg::OFF_CHAN_RESULT);
      `CHK("result", 16'h0008, q)
      wr(16'h0140, 16'h0055);
      wr(dpsc_pkg::OFF_OUT_PROD, 16'h0141);
      rd(dpsc_pkg::OFF_ACT_STAT);
      `CHK("act", 16'h0001, q)
      `CHK("tx_data", 8'h55, tx_data)
      @(posedge mclk_in);
      tx_ready <= 1'b1;
      tx_busy <= 1'b1;
      @(posedge mclk_in);
      tx_ready <= 1'b0;
      rd(dpsc_pkg::OFF_OUT_CONS);
      `CHK("out_cons", 16'h0141, q)
      rd(dpsc_pkg::OFF_ACT_STAT);
      `CHK("act_busy", 16'h0001, q)
      @(posedge mclk_in);
      tx_busy <= 1'b0;
      rd(dpsc_pkg::OFF_ACT_STAT);
      `CHK("act_idle", 16'h0000, q)
      end_sim();
   end
endmodule
